// [rtl/opic_slave.v]
`include "opic_map.vh"

module opic_slave #(
   parameter BLOW_CYC = `OPIC_BLOW_CYC      // fuse blow duration in cycles
) (
   input  wire       I_CLK,          // 50 MHz clock
   input  wire       I_RST,          // async reset, active high
   input  wire       I_CE,           // clock enable, freezes all state when low
   input  wire       I_PIN_ADDR_EN,  // 1 selects pin-configured address variant
   input  wire       I_ADDR_PIN_HIGH,// upper address pin level
   input  wire       I_ADDR_PIN_LOW, // lower address pin level
   input  wire       I_SCL,          // bus clock pin
   input  wire       I_SDA,          // bus data pin input
   output wire       O_SDA,          // bus data output, always low when enabled
   output reg        O_SDA_OE,       // high while pulling data low
   input  wire [1:0] I_FUSE_OK,      // per-channel fuse blow outcome, 1 = all blown
   output reg  [7:0] O_WIPER_CH1,    // applied wiper position channel 1
   output reg  [7:0] O_WIPER_CH2,    // applied wiper position channel 2
   output reg  [1:0] O_SHUTDOWN,     // per-channel shutdown: A open, wiper to B
   output reg  [1:0] O_FUSE_BLOW     // per-channel fuse blow strobe level
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_INSTR = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_RDATA = 3'h4;
   localparam ST_RVAL  = 3'h5;
   localparam ST_WAITA = 3'h6;

   wire scl_s;
   wire sda_s;
   reg  scl_d;
   reg  sda_d;
   reg  [2:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shreg;
   reg  [7:0] tx;
   reg        rd_mode;
   reg        in_ack;
   reg        chan;
   reg  [7:0] wiper      [0:1];
   reg  [7:0] fused      [0:1];
   reg  [1:0] blown;
   reg  [1:0] fatal;
   reg  [1:0] ovr;
   reg  [1:0] shdn;
   reg  [31:0] blow_cnt;
   reg        blow_ch;
   reg        blowing;
   reg        master_nack;
   wire       pin_en_s;
   wire       pin_h_s;
   wire       pin_l_s;
   wire [1:0] fuse_ok_s;
   genvar     gi;

   // both bus pins come from outside this clock domain
   opic_sync u_scl (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_SCL),
      .o_q   (scl_s)
   );
   opic_sync u_sda (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_SDA),
      .o_q   (sda_s)
   );

   // address straps are board pins too; they settle long before any frame
   opic_sync u_pin_en (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_PIN_ADDR_EN),
      .o_q   (pin_en_s)
   );
   opic_sync u_pin_h (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_ADDR_PIN_HIGH),
      .o_q   (pin_h_s)
   );
   opic_sync u_pin_l (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .i_d   (I_ADDR_PIN_LOW),
      .o_q   (pin_l_s)
   );

   // fuse outcome comes from the fuse cells, outside this clock domain
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_fuse_sync
         opic_sync u_fuse_ok (
            .i_clk (I_CLK),
            .i_rst (I_RST),
            .i_ce  (I_CE),
            .i_d   (I_FUSE_OK[gi]),
            .o_q   (fuse_ok_s[gi])
         );
      end
   endgenerate

   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (I_CE) begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // address match, shared by both variants
   function addr_hit;
      input [6:0] a;
      input       pin_en;
      input       ph;
      input       pl;
      begin
         if (pin_en)
            addr_hit = (a == {`OPIC_ADDR_PIN_PREFIX, ph, pl});
         else
            addr_hit = (a == `OPIC_ADDR_FIXED);
      end
   endfunction

   // validation status of one channel
   function [1:0] fuse_status;
      input b;
      input f;
      begin
         if (f)
            fuse_status = `OPIC_ST_FATAL;
         else if (b)
            fuse_status = `OPIC_ST_DONE;
         else
            fuse_status = `OPIC_ST_READY;
      end
   endfunction

   // status and wiper of the selected channel, as sent on a read
   wire [1:0] cur_status = fuse_status(blown[chan], fatal[chan]);
   wire [7:0] cur_wiper  = wiper[chan];

   // open-drain: only ever drives low
   assign O_SDA = 1'b0;

   wire [7:0] next_shreg = {shreg[6:0], sda_s};

   // bus engine: bit counting on clock edges, data changed only on falling edge
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         state       <= ST_IDLE;
         bit_cnt     <= 4'h0;
         shreg       <= 8'h00;
         tx          <= 8'h00;
         rd_mode     <= 1'b0;
         in_ack      <= 1'b0;
         O_SDA_OE    <= 1'b0;
         chan        <= 1'b0;
         master_nack <= 1'b0;
         wiper[0]    <= `OPIC_MIDSCALE;
         wiper[1]    <= `OPIC_MIDSCALE;
         ovr         <= 2'h0;
         shdn        <= 2'h0;
         blowing     <= 1'b0;
         blow_ch     <= 1'b0;
         blow_cnt    <= 32'h0;
      end else if (I_CE) begin
         // fuse blow timer runs independent of the bus
         if (blowing) begin
            if (blow_cnt == 32'h0)
               blowing <= 1'b0;
            else
               blow_cnt <= blow_cnt - 32'h1;
         end
         if (start_c) begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            in_ack   <= 1'b0;
            O_SDA_OE <= 1'b0;
         end else if (stop_c) begin
            state    <= ST_IDLE;
            O_SDA_OE <= 1'b0;
         end else if (state != ST_IDLE) begin
            if (scl_rise && !in_ack) begin
               shreg   <= next_shreg;
               bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_rise && in_ack) begin
               master_nack <= sda_s;
            end else if (scl_fall && in_ack) begin
               // end of ninth pulse: release and move to next byte
               in_ack   <= 1'b0;
               bit_cnt  <= 4'h0;
               O_SDA_OE <= 1'b0;
               if (state == ST_ADDR) begin
                  // read address ack over: first wiper bit must stand before next rise
                  state    <= ST_RDATA;
                  O_SDA_OE <= ~tx[7];
               end else if (state == ST_RDATA || state == ST_RVAL) begin
                  // repeat: data, validation, data, validation until a nack
                  if (master_nack) begin
                     state <= ST_WAITA;
                  end else if (state == ST_RDATA) begin
                     tx       <= {cur_status, 6'h00};
                     state    <= ST_RVAL;
                     O_SDA_OE <= ~cur_status[1];
                  end else begin
                     tx       <= cur_wiper;
                     state    <= ST_RDATA;
                     O_SDA_OE <= ~cur_wiper[7];
                  end
               end
            end else if (scl_fall && !in_ack && bit_cnt == 4'h8) begin
               // eighth bit complete: decide acknowledge
               in_ack <= 1'b1;
               case (state)
                  ST_ADDR: begin
                     if (addr_hit(shreg[7:1], pin_en_s, pin_h_s,
                                  pin_l_s)) begin
                        O_SDA_OE <= 1'b1;
                        rd_mode  <= shreg[0];
                        if (shreg[0]) begin
                           // stays in address state until the ack pulse ends
                           tx    <= wiper[chan];
                        end else begin
                           state <= ST_INSTR;
                        end
                     end else begin
                        state  <= ST_IDLE;
                        in_ack <= 1'b0;
                     end
                  end
                  ST_INSTR: begin
                     O_SDA_OE <= 1'b1;
                     chan     <= shreg[`OPIC_INS_CHAN];
                     // bit 4 from the master is not checked; low bits unused
                     shdn[shreg[`OPIC_INS_CHAN]] <= shreg[`OPIC_INS_SHDN];
                     ovr[shreg[`OPIC_INS_CHAN]]  <= shreg[`OPIC_INS_OVR];
                     if (shreg[`OPIC_INS_PROG] && !blown[shreg[`OPIC_INS_CHAN]]
                         && !blowing) begin
                        blowing  <= 1'b1;
                        blow_ch  <= shreg[`OPIC_INS_CHAN];
                        blow_cnt <= BLOW_CYC - 1;
                     end
                     state <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     O_SDA_OE <= 1'b1;
                     // after blow only override lets a write land
                     if (!blown[chan] || ovr[chan])
                        wiper[chan] <= shreg;
                  end
                  default: begin
                     O_SDA_OE <= 1'b0;
                  end
               endcase
            end else if (scl_fall && !in_ack && rd_mode
                         && (state == ST_RDATA || state == ST_RVAL)) begin
               // shift out next bit, msb first; bit_cnt counts sent bits
               O_SDA_OE <= ~tx[3'h7 - bit_cnt[2:0]];
            end
            // leaving override restores the fused setting
            if (blown[0] && !ovr[0] && !(state == ST_INSTR))
               wiper[0] <= fused[0];
            if (blown[1] && !ovr[1] && !(state == ST_INSTR))
               wiper[1] <= fused[1];
         end
      end
   end

   // fuse bank: latched at end of blow, survives override and restores after
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         blown    <= 2'h0;
         fatal    <= 2'h0;
         fused[0] <= `OPIC_MIDSCALE;
         fused[1] <= `OPIC_MIDSCALE;
      end else if (I_CE) begin
         if (blowing && blow_cnt == 32'h0) begin
            blown[blow_ch] <= 1'b1;
            fatal[blow_ch] <= ~fuse_ok_s[blow_ch];
            fused[blow_ch] <= wiper[blow_ch];
         end
      end
   end

   // applied outputs; shutdown hides but never alters the wiper register
   always @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_WIPER_CH1 <= `OPIC_MIDSCALE;
         O_WIPER_CH2 <= `OPIC_MIDSCALE;
         O_SHUTDOWN  <= 2'h0;
         O_FUSE_BLOW <= 2'h0;
      end else if (I_CE) begin
         O_WIPER_CH1 <= wiper[0];
         O_WIPER_CH2 <= wiper[1];
         O_SHUTDOWN  <= shdn;
         O_FUSE_BLOW <= {blowing & blow_ch, blowing & ~blow_ch};
      end
   end
endmodule // opic_slave

// [rtl/opic_map.vh]
`ifndef OPIC_MAP_VH
`define OPIC_MAP_VH
// slave address forms
`define OPIC_ADDR_FIXED      7'h2F
`define OPIC_ADDR_PIN_PREFIX 5'h0B
// instruction byte field positions
`define OPIC_INS_CHAN        7
`define OPIC_INS_SHDN        6
`define OPIC_INS_PROG        5
`define OPIC_INS_OVR         3
// preset and status values
`define OPIC_MIDSCALE        8'h80
`define OPIC_ST_READY        2'h0
`define OPIC_ST_FATAL        2'h2
`define OPIC_ST_DONE         2'h3
// fuse blow time in ns and cycle count at 50 MHz
`define OPIC_CLK_NS          20
`define OPIC_BLOW_NS         400000000
`define OPIC_BLOW_CYC        (`OPIC_BLOW_NS / `OPIC_CLK_NS)
`endif

// [rtl/opic_sync.v]
// two-stage synchroniser for one bit; first stage feeds only the second
module opic_sync (
   input  wire i_clk,   // local clock
   input  wire i_rst,   // async reset, active high
   input  wire i_ce,    // clock enable
   input  wire i_d,     // asynchronous input
   output reg  o_q      // synchronised output
);
   reg meta;

   // reset to idle-high, the released level of a pulled-up line
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= 1'b1;
         o_q  <= 1'b1;
      end else if (i_ce) begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule // opic_sync

// [verif/opic_slave_properties.sv]
`include "opic_map.vh"

// bus-side and fuse-side timing guards, seen only through the top ports
module opic_slave_properties #(
   parameter BLOW_CYC = 10                          // blow length in cycles
) (
   input wire       I_CLK, I_RST, I_CE, I_PIN_ADDR_EN, // clock, reset, mode
   input wire       I_ADDR_PIN_HIGH, I_ADDR_PIN_LOW,   // address pins
   input wire       I_SCL, I_SDA, O_SDA, O_SDA_OE,     // bus pins
   input wire [1:0] I_FUSE_OK, O_SHUTDOWN, O_FUSE_BLOW,// fuse and shutdown
   input wire [7:0] O_WIPER_CH1, O_WIPER_CH2         // applied wipers
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // the pin may only ever pull low, so only the enable reaches the wire
   sda_pull_low_a: assert property (O_SDA == 1'b0)
      else $error("data pull level is not low");
   // answer bits move only while the bus clock has been low for two samples
   oe_in_low_a: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL) && !$past(I_SCL, 2))
      else $error("data enable moved while bus clock high");
   midscale_a: assert property ($fell(I_RST) |-> O_WIPER_CH1 == `OPIC_MIDSCALE && O_WIPER_CH2 == `OPIC_MIDSCALE)
      else $error("wipers not at midscale after reset");
   rst_quiet_a: assert property ($fell(I_RST) |-> O_SHUTDOWN == 2'h0 && O_FUSE_BLOW == 2'h0 && !O_SDA_OE)
      else $error("outputs not idle after reset");
   // a blow strobe that ends early would leave fuses half set
   blow_len1_a: assert property ($rose(O_FUSE_BLOW[0]) |=> O_FUSE_BLOW[0] [*8])
      else $error("channel 1 blow strobe too short");
   blow_len2_a: assert property ($rose(O_FUSE_BLOW[1]) |=> O_FUSE_BLOW[1] [*8])
      else $error("channel 2 blow strobe too short");
   one_blow_a: assert property (O_FUSE_BLOW != 2'h3)
      else $error("both channels blowing at once");
   shdn_keeps_wiper_a: assert property ($changed(O_SHUTDOWN) |-> $stable(O_WIPER_CH1) && $stable(O_WIPER_CH2))
      else $error("shutdown change disturbed a wiper");
endmodule // opic_slave_properties

bind opic_slave opic_slave_properties #(.BLOW_CYC(BLOW_CYC)) u_props (.*);

// [verif/opic_master.sv]
// behavioural bus master; clock stands high between frames
module opic_master (
   output logic o_scl,      // bus clock
   output logic o_sda_low,  // 1 pulls data low
   input  wire  i_sda       // resolved data wire
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // data falls while clock high
   task start;
      o_sda_low = 1'b1;
      #40 o_scl = 1'b0;
   endtask
   // data moves mid-low and is sampled mid-high, so it is stable while high
   task bitx(input logic b, output logic r);
      #40 o_sda_low = !b;
      #40 o_scl = 1'b1;
      #40 r = i_sda;
      #40 o_scl = 1'b0;
   endtask
   // nine pulses: eight bits msb first, then the ack slot
   task xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) bitx(tx[i], rx[i]);
   endtask
   // data low in the clock low, then rising while clock high
   task stop;
      #40 o_sda_low = 1'b1;
      #40 o_scl = 1'b1;
      #40 o_sda_low = 1'b0;
      #80;
   endtask
endmodule // opic_master

// [verif/opic_slave_tb.sv]
module opic_slave_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLOW = 10;
   logic clk = 1'b0, rst = 1'b1, pin_en = 1'b0, ph = 1'b0, pl = 1'b0;
   logic [1:0] fuse_ok = 2'h1;
   logic [6:0] addr = 7'h2F;
   logic [8:0] rx;
   logic [31:0] lfsr = 32'hAADCFAF3;
   wire scl, m_low, oe, sda_o, sda_pin;
   wire [7:0] w1, w2;
   wire [1:0] shdn, blow;
   int miscompares = 0, n_checks = 0, cycles = 0, sel = 0;
   int wip[2], fuse[2], stat[2], blown[2];
   assign sda_pin = !(m_low | oe); // pulled up unless someone pulls low
   always #10 clk = ~clk;
   opic_slave #(.BLOW_CYC(BLOW)) DUT (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1),
      .I_PIN_ADDR_EN(pin_en), .I_ADDR_PIN_HIGH(ph), .I_ADDR_PIN_LOW(pl),
      .I_SCL(scl), .I_SDA(sda_pin), .O_SDA(sda_o), .O_SDA_OE(oe),
      .I_FUSE_OK(fuse_ok), .O_WIPER_CH1(w1), .O_WIPER_CH2(w2),
      .O_SHUTDOWN(shdn), .O_FUSE_BLOW(blow));
   opic_master m (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda_pin));
   function logic [7:0] rnd8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // model state after power-up: unblown, midscale
   task prst;
      foreach (wip[i]) begin
         wip[i] = 8'h80; fuse[i] = 0; stat[i] = 0; blown[i] = 0;
      end
      sel = 0;
   endtask
   // addressed write: instruction then n random data bytes
   task wr(input logic [7:0] ins, input int n, input bit hit);
      logic [7:0] d;
      int ch;
      ch = ins[7];
      @(negedge clk);
      m.start();
      m.xfer({addr, 1'b0, 1'b1}, rx);
      chk("address ack", rx[0], !hit);
      m.xfer({ins, 1'b1}, rx);
      chk("instruction ack", rx[0], !hit);
      if (hit) begin
         sel = ch;
         if (blown[ch] && !ins[3]) wip[ch] = fuse[ch];
         for (int k = 0; k < n; k++) begin
            d = rnd8();
            m.xfer({d, 1'b1}, rx);
            chk("data ack", rx[0], 1'b0);
            if (!blown[ch] || ins[3]) wip[ch] = d;
            #160 chk("wiper now", ch ? w2 : w1, wip[ch]);
         end
      end
      m.stop();
      #160 chk("wiper ch1", w1, wip[0]);
      chk("wiper ch2", w2, wip[1]);
      if (hit) chk("shutdown", shdn[ch], ins[6]);
      if (hit && ins[5] && !blown[ch]) begin
         // blow takes a fixed strobe, then the outcome is latched
         repeat (BLOW + 10) @(negedge clk);
         blown[ch] = 1; fuse[ch] = wip[ch]; stat[ch] = fuse_ok[ch] ? 3 : 2;
      end
   endtask
   // read pairs of wiper and validation byte, nack on the last
   task rd(input int pairs);
      @(negedge clk);
      m.start();
      m.xfer({addr, 1'b1, 1'b1}, rx);
      chk("read address ack", rx[0], 1'b0);
      for (int k = 0; k < pairs; k++) begin
         m.xfer(9'h1FE, rx);
         chk("read wiper", rx[8:1], wip[sel]);
         m.xfer({8'hFF, k == pairs - 1}, rx);
         chk("fuse status", rx[8:7], stat[sel]);
      end
      m.stop();
   endtask
   // hang guard, well above the longest sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      prst();
      repeat (5) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      repeat (4) @(negedge clk);
      chk("preset ch1", w1, 8'h80);
      wr(8'h07, 2, 1);
      wr(8'h80, 0, 1);
      rd(2);
      wr(8'h81, 1, 1);
      addr = 7'h2E;
      wr(8'h00, 1, 0);
      addr = 7'h2F;
      wr(8'h40, 1, 1);
      wr(8'h00, 0, 1);
      wr(8'h20, 0, 1);
      rd(1);
      wr(8'h00, 1, 1);
      wr(8'h08, 1, 1);
      wr(8'h00, 0, 1);
      fuse_ok = 2'h1;
      wr(8'hA0, 0, 1);
      rd(1);
      rx[7:0] = rnd8();
      @(negedge clk);
      {ph, pl} = rx[1:0];
      pin_en = 1'b1;
      addr = {5'h0B, ph, pl};
      wr(8'h00, 1, 1);
      @(negedge clk) rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      prst();
      repeat (4) @(negedge clk);
      chk("preset ch1", w1, 8'h80);
      chk("preset ch2", w2, 8'h80);
      tally_and_finish();
   end
endmodule // opic_slave_tb
